// >>> inc/pcl_pkg.sv
// Purpose: Shared constants, types and helpers of the pulse-count LED configuration port.
// Assumes: 125 MHz core clock; times are converted to clock cycles here.
// Notes: Cycle counts above 4096 are only defaults; the top module makes them parameters.
package pcl_pkg;

	// Clock and protocol times in their own units.
	localparam int CLK_PERIOD_NS = 8;
	localparam int PULSE_MIN_NS = 200;
	localparam int PULSE_MAX_US = 100;
	localparam int ADDR_DATA_GAP_US = 500;
	localparam real NEXT_ADDR_GAP_MS = 1.5;
	localparam int REPROGRAM_RECOVERY_MS = 2;
	localparam real SHUTDOWN_LOW_MS = 1.5;
	localparam int INIT_DELAY_US = 10;
	localparam int PUMP_STEP_DELAY_US = 800;

	// Cycle counts: least times round up, longest times round down.
	localparam int PULSE_MIN_CYC = (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PULSE_MAX_CYC = (PULSE_MAX_US * 1000) / CLK_PERIOD_NS;
	localparam int ADDR_DATA_GAP_CYC = (ADDR_DATA_GAP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int NEXT_ADDR_GAP_CYC = int'($ceil(NEXT_ADDR_GAP_MS * 1.0e6 / CLK_PERIOD_NS));
	localparam int RECOVERY_CYC = (REPROGRAM_RECOVERY_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SHUTDOWN_LOW_CYC = int'($ceil(SHUTDOWN_LOW_MS * 1.0e6 / CLK_PERIOD_NS));
	localparam int INIT_DELAY_CYC = (INIT_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PUMP_STEP_CYC = (PUMP_STEP_DELAY_US * 1000) / CLK_PERIOD_NS;

	// Counter widths.
	localparam int TIMER_W = 18;
	localparam int FILTER_W = 5;
	localparam int STEP_W = 17;

	// Register indices, selected by the number of address pulses.
	localparam logic [2:0] IDX_RANGE_AND_BANK_ENABLE = 3'h1;
	localparam logic [2:0] IDX_COMMON_CHANNEL_CURRENT = 3'h2;
	localparam logic [2:0] IDX_BANK_C_CURRENT = 3'h3;
	localparam logic [2:0] IDX_BANK_B_CURRENT = 3'h4;
	localparam logic [2:0] IDX_BANK_A_CURRENT = 3'h5;
	localparam logic [2:0] IDX_PUMP_LOCKOUT_RETRIGGER = 3'h6;
	localparam logic [2:0] IDX_OVERFLOW = 3'h7;

	// Field positions and reset value.
	localparam int BIT_BANK_A_ENABLE = 0;
	localparam int BIT_BANK_B_ENABLE = 1;
	localparam int BIT_BANK_C_ENABLE = 2;
	localparam int BIT_CURRENT_RANGE_SELECT = 3;
	localparam int BIT_RETURN_LOCKOUT = 0;
	localparam logic [3:0] REG_RESET = 4'h0;

	typedef enum logic [2:0] {
		ST_INIT = 3'b000,
		ST_OFF = 3'b001,
		ST_WAKE = 3'b010,
		ST_ADDR = 3'b011,
		ST_GAP = 3'b100,
		ST_DATA = 3'b101,
		ST_DONE = 3'b110,
		ST_RECOVER = 3'b111
	} pcl_state_e;

	typedef enum logic [1:0] {
		PUMP_1X = 2'b00,
		PUMP_1X33 = 2'b01,
		PUMP_1X5 = 2'b10,
		PUMP_2X = 2'b11
	} pcl_pump_mode_e;

	typedef struct packed {
		logic current_range_select;
		logic bank_a_enable;
		logic bank_b_enable;
		logic bank_c_enable;
		logic [3:0] common_channel_current;
		logic [3:0] bank_c_current;
		logic [3:0] bank_b_current;
		logic [3:0] bank_a_current;
		logic return_lockout;
	} pcl_cfg_s;

	// True once a duration counter has reached its limit.
	function automatic logic elapsed(input logic [TIMER_W-1:0] t, input logic [TIMER_W-1:0] lim);
		return t >= lim;
	endfunction : elapsed

endpackage : pcl_pkg

// >>> logic/pcl_pump_ctrl.sv
// Purpose: Charge-pump mode controller steered by the lockout bit and retrigger pulse.
// Assumes: Headroom inputs are synchronous levels from the channel monitors.
// Notes: Steps up one ratio after a fixed delay of low headroom; 2x wraps to 1x.
module pcl_pump_ctrl
	import pcl_pkg::*;
#(
	parameter int T_STEP = PUMP_STEP_CYC
)(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Control
	input wire logic enable,
	input wire logic return_lockout,
	input wire logic retrigger,
	// Headroom status
	input wire logic headroom_low,
	input wire logic headroom_ok_1x,
	// Mode
	output pcl_pump_mode_e pump_mode
);

	localparam logic [STEP_W-1:0] STEP_LIM = STEP_W'(T_STEP - 1);

	pcl_pump_mode_e mode_q;
	logic [STEP_W-1:0] step_cnt_q;

	assign pump_mode = mode_q;

	// Counts how long headroom has stayed low.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			step_cnt_q <= '0;
		else if (!enable || retrigger || !headroom_low || step_cnt_q == STEP_LIM)
			step_cnt_q <= '0;
		else
			step_cnt_q <= step_cnt_q + 1'b1;
	end

	// Selects the multiplication ratio.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			mode_q <= PUMP_1X;
		else if (!enable || retrigger)
			mode_q <= PUMP_1X;
		else if (headroom_low && step_cnt_q == STEP_LIM)
		begin
			unique case (mode_q)
				PUMP_1X: mode_q <= PUMP_1X33;
				PUMP_1X33: mode_q <= PUMP_1X5;
				PUMP_1X5: mode_q <= PUMP_2X;
				PUMP_2X: mode_q <= PUMP_1X;
			endcase
		end
		else if (headroom_ok_1x && !return_lockout && mode_q != PUMP_1X)
			mode_q <= PUMP_1X;
	end

endmodule : pcl_pump_ctrl

// >>> logic/pcl_port.sv
// Purpose: Pulse-count programming port and register file of a six-channel LED driver.
// Assumes: The programming line is synchronous to clk; rst stands for power-up.
// Notes: Each data pulse decrements registers one to five, so N pulses leave 0 minus N; register six toggles.
//
// What this block does
// - Six registers: five of four bits and one of a single bit.
// - Address phase counts falling edges; N pulses select register N, up to six.
// - Pulses shorter than 200 ns are filtered out and ignored.
// - After that gap the next falling edge is the first data pulse.
// - Selecting a register clears it at once, before any data.
// - A selected register without data takes the next sequence as data only.
// - On wake the port seeks an address; no edge in 100 us means recovery.
// - Logic needs 10 us after power-up; host keeps the line low meanwhile.
// - Range bit one means full range; zero divides every current by eight.
// - Banks A, B and C are switched on by their own enable bits.
// - Register two sets all channels; three, four, five set banks C, B, A.
// - One data pulse sets the lockout bit; two pulses clear it.
// - With lockout set the pump returns to 1x only by retrigger, the 2x wrap or device disable, and may step up.
// - Writing register six retriggers the pump back to 1x.
// - Line low for 1.5 ms powers the device down and stops all sources.
// - Power-down by a long low level clears all six registers.
// - Undervoltage shuts down, clears registers and locks until restart.
module pcl_port
	import pcl_pkg::*;
#(
	parameter int T_PULSE_MAX = PULSE_MAX_CYC,
	parameter int T_ADDR_DATA_GAP = ADDR_DATA_GAP_CYC,
	parameter int T_NEXT_ADDR_GAP = NEXT_ADDR_GAP_CYC,
	parameter int T_RECOVERY = RECOVERY_CYC,
	parameter int T_SHUTDOWN_LOW = SHUTDOWN_LOW_CYC,
	parameter int T_PUMP_STEP = PUMP_STEP_CYC
)(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Programming line
	input wire logic prog_line,
	// Analog status
	input wire logic supply_undervoltage,
	input wire logic headroom_low,
	input wire logic headroom_ok_1x,
	// Configuration and drive
	output pcl_cfg_s cfg,
	output logic [2:0] bank_on,
	output logic device_enabled,
	output pcl_pump_mode_e pump_mode
);

	localparam logic [FILTER_W-1:0] FLT_LIM = FILTER_W'(PULSE_MIN_CYC - 1);
	localparam logic [TIMER_W-1:0] LIM_INIT = TIMER_W'(INIT_DELAY_CYC);
	localparam logic [TIMER_W-1:0] LIM_PULSE = TIMER_W'(T_PULSE_MAX);
	localparam logic [TIMER_W-1:0] LIM_GAP = TIMER_W'(T_ADDR_DATA_GAP);
	localparam logic [TIMER_W-1:0] LIM_NEXT = TIMER_W'(T_NEXT_ADDR_GAP);
	localparam logic [TIMER_W-1:0] LIM_RECOV = TIMER_W'(T_RECOVERY);
	localparam logic [TIMER_W-1:0] LIM_OFF = TIMER_W'(T_SHUTDOWN_LOW);

	pcl_state_e state_q, state_d;
	logic line_q;
	logic line_p_q;
	logic [FILTER_W-1:0] flt_cnt_q;
	logic [TIMER_W-1:0] timer_q;
	logic [2:0] addr_cnt_q;
	logic [2:0] sel_idx_q;
	logic [3:0] regs_q [1:6];
	logic uvlo_lock_q;
	logic retrig_q;
	logic enabled_q;
	logic [2:0] bank_on_q;
	logic fall;
	logic rise;
	logic addr_start;
	logic addr_inc;
	logic sel_fire;
	logic data_fire;
	logic clear_all;

	// Next value of a register after one data pulse.
	function automatic logic [3:0] pulse_dec(input logic [3:0] v, input logic [2:0] idx);
		if (idx == IDX_PUMP_LOCKOUT_RETRIGGER)
			return {3'h0, ~v[BIT_RETURN_LOCKOUT]};
		else
			return v - 4'h1;
	endfunction : pulse_dec

	assign fall = line_p_q & ~line_q;
	assign rise = ~line_p_q & line_q;

	// Glitch filter: the level must differ for the minimum pulse time to be taken.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			line_q <= 1'b0;
			flt_cnt_q <= '0;
		end
		else if (prog_line == line_q)
			flt_cnt_q <= '0;
		else if (flt_cnt_q == FLT_LIM)
		begin
			line_q <= prog_line;
			flt_cnt_q <= '0;
		end
		else
			flt_cnt_q <= flt_cnt_q + 1'b1;
	end

	// Delayed filtered level for edge detection.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			line_p_q <= 1'b0;
		else
			line_p_q <= line_q;
	end

	// Duration of the current filtered level, saturating.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			timer_q <= '0;
		else if (fall || rise)
			timer_q <= '0;
		else if (timer_q != '1)
			timer_q <= timer_q + 1'b1;
	end

	// Sequencer of the programming protocol.
	always_comb
	begin
		state_d = state_q;
		addr_start = 1'b0;
		addr_inc = 1'b0;
		sel_fire = 1'b0;
		data_fire = 1'b0;
		clear_all = 1'b0;
		unique case (state_q)
			ST_INIT:
			begin
				if (!line_q && elapsed(timer_q, LIM_INIT))
					state_d = ST_OFF;
			end
			ST_OFF:
			begin
				if (line_q && !uvlo_lock_q)
					state_d = ST_WAKE;
			end
			ST_WAKE:
			begin
				if (fall)
				begin
					addr_start = 1'b1;
					state_d = ST_ADDR;
				end
				else if (elapsed(timer_q, LIM_PULSE))
					state_d = ST_RECOVER;
			end
			ST_ADDR:
			begin
				if (fall)
					addr_inc = 1'b1;
				else if (line_q && elapsed(timer_q, LIM_PULSE))
				begin
					if (addr_cnt_q != IDX_OVERFLOW)
					begin
						sel_fire = 1'b1;
						state_d = ST_GAP;
					end
					else
						state_d = ST_RECOVER;
				end
				else if (!line_q && elapsed(timer_q, LIM_PULSE))
					state_d = ST_RECOVER;
			end
			ST_GAP:
			begin
				if (fall)
				begin
					if (elapsed(timer_q, LIM_GAP))
					begin
						data_fire = 1'b1;
						state_d = ST_DATA;
					end
					else
						state_d = ST_RECOVER;
				end
			end
			ST_DATA:
			begin
				if (fall)
					data_fire = 1'b1;
				else if (line_q && elapsed(timer_q, LIM_PULSE))
					state_d = ST_DONE;
				else if (!line_q && elapsed(timer_q, LIM_PULSE))
					state_d = ST_RECOVER;
			end
			ST_DONE:
			begin
				if (fall)
				begin
					if (elapsed(timer_q, LIM_NEXT))
					begin
						addr_start = 1'b1;
						state_d = ST_ADDR;
					end
					else
						state_d = ST_RECOVER;
				end
			end
			ST_RECOVER:
			begin
				if (line_q && elapsed(timer_q, LIM_RECOV))
					state_d = ST_DONE;
			end
		endcase
		if (state_q != ST_INIT && state_q != ST_OFF && !line_q && timer_q == LIM_OFF)
		begin
			clear_all = 1'b1;
			state_d = ST_OFF;
		end
		if (supply_undervoltage || uvlo_lock_q)
		begin
			clear_all = 1'b1;
			state_d = (state_q == ST_INIT) ? ST_INIT : ST_OFF;
			addr_start = 1'b0;
			addr_inc = 1'b0;
			sel_fire = 1'b0;
			data_fire = 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			state_q <= ST_INIT;
		else
			state_q <= state_d;
	end

	// Address pulse counter, saturating past the last register.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			addr_cnt_q <= 3'h0;
		else if (addr_start)
			addr_cnt_q <= IDX_RANGE_AND_BANK_ENABLE;
		else if (addr_inc && addr_cnt_q != IDX_OVERFLOW)
			addr_cnt_q <= addr_cnt_q + 3'h1;
	end

	// Register chosen by the last complete address.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			sel_idx_q <= IDX_RANGE_AND_BANK_ENABLE;
		else if (sel_fire)
			sel_idx_q <= addr_cnt_q;
	end

	// Register file.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			for (int i = 1; i <= 6; i++)
				regs_q[i] <= REG_RESET;
		end
		else if (clear_all)
		begin
			for (int i = 1; i <= 6; i++)
				regs_q[i] <= REG_RESET;
		end
		else if (sel_fire)
			regs_q[addr_cnt_q] <= REG_RESET;
		else if (data_fire)
			regs_q[sel_idx_q] <= pulse_dec(regs_q[sel_idx_q], sel_idx_q);
	end

	// Undervoltage lockout, released only by a restart.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			uvlo_lock_q <= 1'b0;
		else if (supply_undervoltage)
			uvlo_lock_q <= 1'b1;
	end

	// Retrigger pulse on every data pulse into the lockout register.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			retrig_q <= 1'b0;
		else
			retrig_q <= data_fire && sel_idx_q == IDX_PUMP_LOCKOUT_RETRIGGER;
	end

	// Device enable and bank drive.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			enabled_q <= 1'b0;
			bank_on_q <= 3'h0;
		end
		else
		begin
			enabled_q <= state_d != ST_INIT && state_d != ST_OFF;
			bank_on_q[0] <= state_d != ST_OFF && state_d != ST_INIT
				&& regs_q[IDX_RANGE_AND_BANK_ENABLE][BIT_BANK_A_ENABLE];
			bank_on_q[1] <= state_d != ST_OFF && state_d != ST_INIT
				&& regs_q[IDX_RANGE_AND_BANK_ENABLE][BIT_BANK_B_ENABLE];
			bank_on_q[2] <= state_d != ST_OFF && state_d != ST_INIT
				&& regs_q[IDX_RANGE_AND_BANK_ENABLE][BIT_BANK_C_ENABLE];
		end
	end

	// Register contents seen by the current regulators.
	assign cfg.current_range_select = regs_q[IDX_RANGE_AND_BANK_ENABLE][BIT_CURRENT_RANGE_SELECT];
	assign cfg.bank_a_enable = regs_q[IDX_RANGE_AND_BANK_ENABLE][BIT_BANK_A_ENABLE];
	assign cfg.bank_b_enable = regs_q[IDX_RANGE_AND_BANK_ENABLE][BIT_BANK_B_ENABLE];
	assign cfg.bank_c_enable = regs_q[IDX_RANGE_AND_BANK_ENABLE][BIT_BANK_C_ENABLE];
	assign cfg.common_channel_current = regs_q[IDX_COMMON_CHANNEL_CURRENT];
	assign cfg.bank_c_current = regs_q[IDX_BANK_C_CURRENT];
	assign cfg.bank_b_current = regs_q[IDX_BANK_B_CURRENT];
	assign cfg.bank_a_current = regs_q[IDX_BANK_A_CURRENT];
	assign cfg.return_lockout = regs_q[IDX_PUMP_LOCKOUT_RETRIGGER][BIT_RETURN_LOCKOUT];
	assign bank_on = bank_on_q;
	assign device_enabled = enabled_q;

	// Charge-pump mode controller.
	pcl_pump_ctrl #(
		.T_STEP(T_PUMP_STEP)
	) u_pump (
		.clk(clk),
		.rst(rst),
		.enable(enabled_q),
		.return_lockout(cfg.return_lockout),
		.retrigger(retrig_q),
		.headroom_low(headroom_low),
		.headroom_ok_1x(headroom_ok_1x),
		.pump_mode(pump_mode)
	);

endmodule : pcl_port

// >>> tb/pcl_port_chk.sv
// Purpose: Port checks of the pulse-count configuration port.
// Assumes: One clock domain; rst is asynchronous and active high.
// Notes: Line filter latency is taken as 25 to 30 cycles.
module pcl_port_chk
	import pcl_pkg::*;
#(
	parameter int T_SHUTDOWN_LOW = SHUTDOWN_LOW_CYC,
	parameter int T_PUMP_STEP = PUMP_STEP_CYC
)(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Inputs
	input wire logic prog_line,
	input wire logic supply_undervoltage,
	input wire logic headroom_low,
	input wire logic headroom_ok_1x,
	// Outputs
	input wire pcl_cfg_s cfg,
	input wire logic [2:0] bank_on,
	input wire logic device_enabled,
	input wire logic [1:0] pump_mode
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [19:0] lo_cnt_q;
	logic [7:0] hi_cnt_q;
	logic [STEP_W-1:0] hl_cnt_q;

	// Counts consecutive cycles of low line, high line and low headroom.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			lo_cnt_q <= '0;
			hi_cnt_q <= '0;
			hl_cnt_q <= '0;
		end
		else
		begin
			lo_cnt_q <= prog_line ? '0 : lo_cnt_q + {19'h0, ~&lo_cnt_q};
			hi_cnt_q <= prog_line ? hi_cnt_q + {7'h0, ~&hi_cnt_q} : '0;
			hl_cnt_q <= (headroom_low && device_enabled) ? hl_cnt_q + 1'b1 : '0;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_dead;
		cfg == '0 && !device_enabled && bank_on == 3'h0;
	endsequence

	bank_drive_a:
	assert property (device_enabled && $past(device_enabled) && $stable(cfg)
		|-> bank_on == {cfg.bank_c_enable, cfg.bank_b_enable, cfg.bank_a_enable})
		else $error("bank drive mismatch");
	uv_clear_a:
	assert property (supply_undervoltage |-> ##2 s_dead [*8])
		else $error("undervoltage did not clear");
	shut_clear_a:
	assert property (lo_cnt_q == 20'(T_SHUTDOWN_LOW + 32) |-> s_dead)
		else $error("long low did not clear");
	wake_filter_a:
	assert property ($rose(device_enabled) |-> hi_cnt_q >= 8'd25 && hi_cnt_q <= 8'd30)
		else $error("wake timing wrong");
	lock_hold_a:
	assert property (device_enabled && cfg.return_lockout && $stable(cfg)
		&& cfg == $past(cfg, 3) && pump_mode != PUMP_1X && pump_mode != PUMP_2X
		|=> pump_mode != PUMP_1X || !device_enabled)
		else $error("pump fell back under lockout");
	retrig_pump_a:
	assert property ($rose(cfg.return_lockout) |-> ##[1:2] pump_mode == PUMP_1X)
		else $error("pump not retriggered");
	relax_pump_a:
	assert property (device_enabled && !cfg.return_lockout && headroom_ok_1x
		&& !headroom_low && pump_mode != PUMP_1X |=> pump_mode == PUMP_1X)
		else $error("pump did not return");
	step_up_a:
	assert property ($changed(pump_mode) && pump_mode != PUMP_1X
		|-> $past(hl_cnt_q) >= T_PUMP_STEP - 2)
		else $error("pump stepped early");
endmodule : pcl_port_chk

bind pcl_port pcl_port_chk #(.T_SHUTDOWN_LOW(T_SHUTDOWN_LOW), .T_PUMP_STEP(T_PUMP_STEP)) u_chk (
	.clk(clk), .rst(rst), .prog_line(prog_line), .supply_undervoltage(supply_undervoltage),
	.headroom_low(headroom_low), .headroom_ok_1x(headroom_ok_1x), .cfg(cfg),
	.bank_on(bank_on), .device_enabled(device_enabled), .pump_mode(pump_mode)
);

// >>> tb/pcl_host.sv
// Purpose: Host model driving the pulse programming line.
// Assumes: Called from one process, just after a rising clock edge.
// Notes: Times are in clock cycles.
module pcl_host
(
	// Clock
	input wire logic clk,
	// Programming line
	output logic prog_line
);
	timeunit 1ns;
	timeprecision 1ps;

	initial prog_line = 1'b0;

	task automatic drive(input logic v, input int c);
		prog_line <= v;
		repeat (c) @(posedge clk);
	endtask : drive

	task automatic pulses(input int n);
		repeat (n)
		begin
			drive(1'b0, 30);
			drive(1'b1, 30);
		end
	endtask : pulses
endmodule : pcl_host

// >>> tb/tb_pcl_port.sv
// Purpose: Self-checking bench of the pulse-count configuration port.
// Assumes: Shortened timing parameters; the host model drives the line.
// Notes: Data pulses count fields one to five down from zero and toggle field six.
module tb_pcl_port
	import pcl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst, prog_line, supply_undervoltage, headroom_low, headroom_ok_1x;
	pcl_cfg_s cfg;
	logic [2:0] bank_on;
	logic device_enabled;
	pcl_pump_mode_e pump_mode;
	int error_cnt, num_checks, cyc;

	pcl_host u_host (.clk(clk), .prog_line(prog_line));

	localparam int TB_PULSE_MAX = 50;
	localparam int TB_ADDR_DATA_GAP = 4 * TB_PULSE_MAX;
	localparam int TB_NEXT_ADDR_GAP = 8 * TB_PULSE_MAX;
	localparam int TB_RECOVERY = 10 * TB_PULSE_MAX;
	localparam int TB_SHUTDOWN_LOW = 16 * TB_PULSE_MAX;
	localparam int TB_PUMP_STEP = 20;

	pcl_port #(.T_PULSE_MAX(TB_PULSE_MAX), .T_ADDR_DATA_GAP(TB_ADDR_DATA_GAP),
		.T_NEXT_ADDR_GAP(TB_NEXT_ADDR_GAP), .T_RECOVERY(TB_RECOVERY),
		.T_SHUTDOWN_LOW(TB_SHUTDOWN_LOW), .T_PUMP_STEP(TB_PUMP_STEP)) uut (
		.clk(clk), .rst(rst), .prog_line(prog_line), .supply_undervoltage(supply_undervoltage),
		.headroom_low(headroom_low), .headroom_ok_1x(headroom_ok_1x), .cfg(cfg),
		.bank_on(bank_on), .device_enabled(device_enabled), .pump_mode(pump_mode));

	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic give_verdict();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : give_verdict

	task automatic check(input string what, input logic [21:0] exp, input logic [21:0] got);
		num_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	function automatic logic [3:0] field(input int a);
		case (a)
			1: return {cfg.current_range_select, cfg.bank_c_enable, cfg.bank_b_enable,
				cfg.bank_a_enable};
			2: return cfg.common_channel_current;
			3: return cfg.bank_c_current;
			4: return cfg.bank_b_current;
			5: return cfg.bank_a_current;
			default: return {3'h0, cfg.return_lockout};
		endcase
	endfunction : field

	task automatic wr_tail(input int a, input int d, input int g);
		logic [3:0] exp;
		exp = (a == 6) ? 4'(d % 2) : 4'(16 - d);
		u_host.drive(1'b1, 60);
		check("selected field", 22'(0), 22'(field(a)));
		u_host.drive(1'b1, g);
		u_host.pulses(d);
		u_host.drive(1'b1, 420);
		check("written field", 22'(exp), 22'(field(a)));
	endtask : wr_tail

	task automatic wr(input int a, input int d);
		u_host.pulses(a);
		wr_tail(a, d, 150);
	endtask : wr

	task automatic step_up();
		headroom_low <= 1'b1;
		repeat (TB_PUMP_STEP + 5) @(posedge clk);
		headroom_low <= 1'b0;
		@(posedge clk);
	endtask : step_up

	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 40000)
		begin
			error_cnt++;
			give_verdict();
		end
	end

	initial
	begin
		rst <= 1'b1;
		supply_undervoltage <= 1'b0;
		headroom_low <= 1'b0;
		headroom_ok_1x <= 1'b0;
		error_cnt = 0;
		num_checks = 0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		check("reset cfg", 22'(0), cfg);
		check("reset outputs", 22'(0), 22'({device_enabled, bank_on, pump_mode}));
		u_host.drive(1'b0, 1300);
		u_host.drive(1'b1, 35);
		check("wake", 22'(1), 22'(device_enabled));
		wr(1, 1);
		check("bank drive", 22'(7), 22'(bank_on));
		wr(1, 10);
		check("bank drive", 22'(6), 22'(bank_on));
		for (int i = 2; i < 6; i++)
			wr(i, 2 * i - 1);
		u_host.drive(1'b0, 24);
		u_host.drive(1'b1, 450);
		wr(2, 4);
		check("reg one kept", 22'(6), 22'(field(1)));
		u_host.pulses(3);
		wr_tail(3, 2, 1000);
		u_host.pulses(4);
		u_host.drive(1'b1, 90);
		u_host.pulses(3);
		u_host.drive(1'b1, 600);
		check("early data", 22'(0), 22'(cfg.bank_b_current));
		wr(4, 7);
		step_up();
		check("pump step", 22'(PUMP_1X33), 22'(pump_mode));
		wr(6, 1);
		check("pump retrigger", 22'(PUMP_1X), 22'(pump_mode));
		u_host.pulses(7);
		u_host.drive(1'b1, 600);
		check("overflow", 22'(1), 22'(field(6)));
		step_up();
		headroom_ok_1x <= 1'b1;
		repeat (10) @(posedge clk);
		check("pump held", 22'(PUMP_1X33), 22'(pump_mode));
		step_up();
		step_up();
		check("pump top", 22'(PUMP_2X), 22'(pump_mode));
		wr(6, 2);
		check("pump back", 22'(PUMP_1X), 22'(pump_mode));
		u_host.drive(1'b0, 850);
		check("long low", 22'(0), cfg);
		check("long low off", 22'(0), 22'({device_enabled, bank_on}));
		u_host.drive(1'b1, 35);
		wr(1, 1);
		supply_undervoltage <= 1'b1;
		repeat (3) @(posedge clk);
		supply_undervoltage <= 1'b0;
		u_host.pulses(1);
		u_host.drive(1'b1, 700);
		check("undervoltage", 22'(0), cfg);
		check("undervoltage off", 22'(0), 22'({device_enabled, bank_on, pump_mode}));
		give_verdict();
	end
endmodule : tb_pcl_port
